// ### pkg/fp_single_map.svh
/*
 Field positions, encodings and fixed figures of the single-precision word.
 Assumes it is included by bare name from the design files.
*/
`ifndef FP_SINGLE_MAP_SVH
`define FP_SINGLE_MAP_SVH

`define FP_SIGN_BIT 31
`define FP_EXP_HI 30
`define FP_EXP_LO 23
`define FP_FRAC_HI 22
`define FP_FRAC_LO 0
`define FP_SIG_W 24
`define FP_EXP_W 10
`define FP_BIAS 127
`define FP_EMIN (-126)
`define FP_EMAX 127
`define FP_EXP_ZERO 8'h00
`define FP_EXP_ALL_ONES 8'hFF
`define FP_FRAC_ZERO 23'h000000
`define FP_INDEF_WORD 32'hFFC00000
`define FP_LATENCY 1

`endif

// ### pkg/fp_single_pkg.sv
/*
 Types shared by the single-precision classifier and datapath.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package fp_single_pkg;

	typedef enum logic [2:0]
	{
		cls_zero,
		cls_denormal,
		cls_normal,
		cls_infinity,
		cls_nan,
		cls_indefinite
	} fp_class_t;

endpackage

`default_nettype wire

// ### src/fp_classify.sv
/*
 Combinational decoder and classifier for one single-precision word.
 Assumes the caller registers the outputs; no clock is used here.
*/
`default_nettype none
`include "fp_single_map.svh"

module fp_classify
(
	input wire logic [31:0] word,
	output fp_single_pkg::fp_class_t cls,
	output logic quiet,
	output logic sign,
	output logic signed [`FP_EXP_W-1:0] true_exp,
	output logic [`FP_SIG_W-1:0] sig
);

	logic [7:0] bexp;
	logic [22:0] frac;

	assign bexp = word[`FP_EXP_HI:`FP_EXP_LO]; // RULE_17
	assign frac = word[`FP_FRAC_HI:`FP_FRAC_LO];
	assign sign = word[`FP_SIGN_BIT]; // RULE_01

	always_comb
	begin
		cls = fp_single_pkg::cls_normal; // RULE_06
		quiet = 1'b0;
		if (word == `FP_INDEF_WORD)
		begin
			cls = fp_single_pkg::cls_indefinite; // RULE_11
			quiet = 1'b1;
		end
		else if (bexp == `FP_EXP_ALL_ONES)
		begin
			if (frac == `FP_FRAC_ZERO)
				cls = fp_single_pkg::cls_infinity; // RULE_15
			else
			begin
				cls = fp_single_pkg::cls_nan; // RULE_16
				quiet = frac[`FP_FRAC_HI];
			end
		end
		else if (bexp == `FP_EXP_ZERO)
		begin
			if (frac == `FP_FRAC_ZERO)
				cls = fp_single_pkg::cls_zero; // RULE_10
			else
				cls = fp_single_pkg::cls_denormal; // RULE_07
		end
	end

	// Integer bit is implied by a nonzero exponent field; denormals scale as the minimum exponent
	always_comb
	begin
		sig = {(bexp != `FP_EXP_ZERO), frac}; // RULE_03 RULE_02
		if (bexp == `FP_EXP_ZERO)
			true_exp = `FP_EXP_W'(`FP_EMIN); // RULE_07
		else
			true_exp = $signed({2'h0, bexp}) - `FP_EXP_W'(`FP_BIAS); // RULE_04
	end

endmodule

`default_nettype wire

// ### src/fp_single_unit.sv
/*
 Single-precision operand decode/classify and result normalize/denormalize datapath,
 one register stage deep. Assumes operands and raw results come from logic on the same clock.
*/
// Functional notes
// RULE_01: A sign bit of 0 means positive and 1 means negative.
// RULE_02: The significand is a one-bit integer part and a fraction scaled by a power of two.
// RULE_03: The integer bit is not stored and is rebuilt when an operand is decoded.
// RULE_04: Exponents are stored with 127 added and the bias is removed on decode.
// RULE_05: Normalizing removes leading zeros and lowers the exponent by one per zero.
// RULE_06: Biased exponents 1 to 254, true -126 to +127, are normal finite numbers.
// RULE_07: A zero exponent field is a denormal encoding whose integer bit is zero.
// RULE_08: A result below exponent -126 is shifted right one place per step up to -126.
// RULE_09: If all significant bits are shifted out the result is zero.
// RULE_10: Zero has either sign and both zeros compare equal.
// RULE_11: Every encoding falls into exactly one of six classes.
// RULE_12: Results are normalized when the range allows and denormal only otherwise.
// RULE_13: Producing a denormal result raises the underflow indication.
// RULE_14: Consuming a denormal source raises the denormal-operand indication.
// RULE_15: Infinity is the all-ones exponent with a zero fraction.
// RULE_16: All-ones exponent with nonzero fraction is a NaN, quiet when the top fraction bit is set.
// RULE_17: The word holds sign in bit 31, exponent in 30 to 23 and fraction in 22 to 0.
`default_nettype none
`include "fp_single_map.svh"

module fp_single_unit
#(
	parameter int SIG_W = `FP_SIG_W,
	parameter int EXP_W = `FP_EXP_W
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic [31:0] a_word,
	input wire logic [31:0] b_word,
	input wire logic res_valid,
	input wire logic res_sign,
	input wire logic signed [EXP_W-1:0] res_exp,
	input wire logic [SIG_W-1:0] res_sig,
	output fp_single_pkg::fp_class_t a_class_ff,
	output fp_single_pkg::fp_class_t b_class_ff,
	output logic a_quiet_ff,
	output logic b_quiet_ff,
	output logic a_neg_ff,
	output logic b_neg_ff,
	output logic signed [EXP_W-1:0] a_exp_ff,
	output logic signed [EXP_W-1:0] b_exp_ff,
	output logic [SIG_W-1:0] a_sig_ff,
	output logic [SIG_W-1:0] b_sig_ff,
	output logic op_valid_ff,
	output logic equal_ff,
	output logic denorm_operand_ff,
	output logic res_valid_ff,
	output logic [31:0] res_word_ff,
	output fp_single_pkg::fp_class_t res_class_ff,
	output logic underflow_ff,
	output logic overflow_ff
);

	localparam logic signed [10:0] EMIN_X = 11'(`FP_EMIN);
	localparam logic signed [10:0] EMAX_X = 11'(`FP_EMAX);
	localparam logic signed [10:0] BIAS_X = 11'(`FP_BIAS);
	localparam logic signed [10:0] SIG_W_X = 11'(SIG_W);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [4:0] lead_zeros(input logic [SIG_W-1:0] v);
		logic [4:0] n;
		logic hit;
		n = 5'(SIG_W);
		hit = 1'b0;
		for (int i = SIG_W - 1; i >= 0; i--)
		begin
			if (!hit && v[i])
			begin
				n = 5'(SIG_W - 1 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction

	function automatic logic is_nan_like(input fp_single_pkg::fp_class_t c);
		return (c == fp_single_pkg::cls_nan) || (c == fp_single_pkg::cls_indefinite);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Operand decode

	fp_single_pkg::fp_class_t a_cls;
	fp_single_pkg::fp_class_t b_cls;
	logic a_q;
	logic b_q;
	logic a_s;
	logic b_s;
	logic signed [EXP_W-1:0] a_e;
	logic signed [EXP_W-1:0] b_e;
	logic [SIG_W-1:0] a_m;
	logic [SIG_W-1:0] b_m;

	fp_classify u_class_a
	(
		.word(a_word),
		.cls(a_cls),
		.quiet(a_q),
		.sign(a_s),
		.true_exp(a_e),
		.sig(a_m)
	);

	fp_classify u_class_b
	(
		.word(b_word),
		.cls(b_cls),
		.quiet(b_q),
		.sign(b_s),
		.true_exp(b_e),
		.sig(b_m)
	);

	fp_single_pkg::fp_class_t nxt_a_class_ff;
	fp_single_pkg::fp_class_t nxt_b_class_ff;
	logic nxt_equal_ff;
	logic nxt_denorm_operand_ff;

	always_comb
	begin
		nxt_a_class_ff = a_cls;
		nxt_b_class_ff = b_cls;
		// Sign is ignored between the two zeros; NaNs never compare equal
		nxt_equal_ff = !is_nan_like(a_cls) && !is_nan_like(b_cls) &&
			((a_cls == fp_single_pkg::cls_zero && b_cls == fp_single_pkg::cls_zero) ||
			(a_word == b_word)); // RULE_10
		nxt_denorm_operand_ff = op_valid &&
			(a_cls == fp_single_pkg::cls_denormal || b_cls == fp_single_pkg::cls_denormal); // RULE_14
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_class_ff <= fp_single_pkg::cls_zero;
			b_class_ff <= fp_single_pkg::cls_zero;
			a_quiet_ff <= 1'b0;
			b_quiet_ff <= 1'b0;
			a_neg_ff <= 1'b0;
			b_neg_ff <= 1'b0;
			a_exp_ff <= '0;
			b_exp_ff <= '0;
			a_sig_ff <= '0;
			b_sig_ff <= '0;
			op_valid_ff <= 1'b0;
			equal_ff <= 1'b0;
			denorm_operand_ff <= 1'b0;
		end
		else
		begin
			a_class_ff <= nxt_a_class_ff;
			b_class_ff <= nxt_b_class_ff;
			a_quiet_ff <= a_q;
			b_quiet_ff <= b_q;
			a_neg_ff <= a_s;
			b_neg_ff <= b_s;
			a_exp_ff <= a_e;
			b_exp_ff <= b_e;
			a_sig_ff <= a_m;
			b_sig_ff <= b_m;
			op_valid_ff <= op_valid;
			equal_ff <= nxt_equal_ff;
			denorm_operand_ff <= nxt_denorm_operand_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result normalize / gradual underflow

	logic signed [10:0] exp_x;
	logic signed [10:0] room;
	logic signed [10:0] rsh;
	logic [4:0] lz;
	logic [4:0] lsh;
	logic [SIG_W-1:0] n_sig;
	logic signed [10:0] n_exp;
	logic n_ovf;
	logic [31:0] nxt_res_word_ff;
	logic nxt_underflow_ff;
	logic nxt_overflow_ff;

	assign exp_x = 11'(res_exp);
	assign room = exp_x - EMIN_X;
	assign rsh = EMIN_X - exp_x;
	assign lz = lead_zeros(res_sig);

	always_comb
	begin
		n_sig = '0;
		n_exp = EMIN_X;
		lsh = 5'h00;
		if (res_sig == '0)
		begin
			n_sig = '0;
		end
		else if (exp_x < EMIN_X)
		begin
			// Bits shifted past the bottom are dropped; no rounding is done here
			if (rsh >= SIG_W_X)
				n_sig = '0; // RULE_09
			else
				n_sig = res_sig >> rsh[4:0]; // RULE_08
		end
		else
		begin
			// Stop normalizing at the minimum exponent so the value is kept
			if ({6'h00, lz} < room)
				lsh = lz; // RULE_05
			else
				lsh = room[4:0]; // RULE_12
			n_sig = res_sig << lsh;
			n_exp = exp_x - {6'h00, lsh}; // RULE_05
		end
	end

	always_comb
	begin
		n_ovf = (n_exp > EMAX_X) && (n_sig != '0);
		if (n_ovf)
			nxt_res_word_ff = {res_sign, `FP_EXP_ALL_ONES, `FP_FRAC_ZERO}; // RULE_15
		else if (n_sig[SIG_W-1])
			nxt_res_word_ff = {res_sign, 8'(n_exp + BIAS_X), n_sig[SIG_W-2:0]}; // RULE_17 RULE_04 RULE_03
		else
			nxt_res_word_ff = {res_sign, `FP_EXP_ZERO, n_sig[SIG_W-2:0]}; // RULE_07 RULE_10
		nxt_underflow_ff = res_valid && !n_ovf && !n_sig[SIG_W-1] && (n_sig != '0); // RULE_13
		nxt_overflow_ff = res_valid && n_ovf;
	end

	fp_single_pkg::fp_class_t r_cls;

	fp_classify u_class_res
	(
		.word(nxt_res_word_ff),
		.cls(r_cls),
		.quiet(),
		.sign(),
		.true_exp(),
		.sig()
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_valid_ff <= 1'b0;
			res_word_ff <= '0;
			res_class_ff <= fp_single_pkg::cls_zero;
			underflow_ff <= 1'b0;
			overflow_ff <= 1'b0;
		end
		else
		begin
			res_valid_ff <= res_valid;
			res_word_ff <= nxt_res_word_ff;
			res_class_ff <= r_cls;
			underflow_ff <= nxt_underflow_ff;
			overflow_ff <= nxt_overflow_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_plain_in;
		res_valid && res_sig == 24'h000001 && res_exp == 10'h000;
	endsequence

	sequence s_plain_out;
		res_valid_ff && res_word_ff[30:23] == 8'h68 && res_word_ff[22:0] == 23'h000000;
	endsequence

	sequence s_tiny_in;
		res_valid && res_exp == -10'sd129 && res_sig == 24'hAE0000;
	endsequence

	sequence s_tiny_out;
		res_word_ff[30:0] == 31'h0015C000 && underflow_ff;
	endsequence

	property p_sign;
		op_valid |=> a_neg_ff == $past(a_word[31]) && b_neg_ff == $past(b_word[31]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign not decoded"); // RULE_01

	property p_hidden;
		a_class_ff == fp_single_pkg::cls_normal |-> a_sig_ff[23] && a_sig_ff[22:0] == $past(a_word[22:0]);
	endproperty
	a_hidden: assert property (p_hidden) else $error("integer bit missing"); // RULE_03

	property p_bias;
		op_valid && a_word[30:23] == 8'h86 |=> a_exp_ff == 10'sd7 && a_class_ff == fp_single_pkg::cls_normal;
	endproperty
	a_bias: assert property (p_bias) else $error("bias not removed"); // RULE_04

	property p_norm_range;
		a_class_ff == fp_single_pkg::cls_normal |-> a_exp_ff >= -10'sd126 && a_exp_ff <= 10'sd127;
	endproperty
	a_norm_range: assert property (p_norm_range) else $error("normal exponent out of range"); // RULE_06

	property p_denorm_op;
		op_valid && a_word[30:23] == 8'h00 && a_word[22:0] != 23'h000000
			|=> denorm_operand_ff && a_class_ff == fp_single_pkg::cls_denormal && !a_sig_ff[23];
	endproperty
	a_denorm_op: assert property (p_denorm_op) else $error("denormal operand missed"); // RULE_14

	property p_normalize;
		s_plain_in |=> s_plain_out ##0 !underflow_ff;
	endproperty
	a_normalize: assert property (p_normalize) else $error("normalization wrong"); // RULE_05

	property p_gradual;
		s_tiny_in |=> s_tiny_out;
	endproperty
	a_gradual: assert property (p_gradual) else $error("gradual underflow wrong"); // RULE_08

	property p_flush;
		res_valid && res_exp <= -10'sd150 |=> res_word_ff[30:0] == 31'h00000000 && !underflow_ff;
	endproperty
	a_flush: assert property (p_flush) else $error("flush to zero missing"); // RULE_09

	property p_underflow;
		underflow_ff |-> res_valid_ff && res_class_ff == fp_single_pkg::cls_denormal;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow without denormal"); // RULE_13

	property p_zero_eq;
		op_valid && a_word[30:0] == 31'h0 && b_word[30:0] == 31'h0 |=> equal_ff;
	endproperty
	a_zero_eq: assert property (p_zero_eq) else $error("signed zeros unequal"); // RULE_10

	property p_nan;
		op_valid && a_word[30:23] == 8'hFF && a_word[22:0] != 23'h0 && a_word != 32'hFFC00000
			|=> a_class_ff == fp_single_pkg::cls_nan && a_quiet_ff == $past(a_word[22]) && !equal_ff;
	endproperty
	a_nan: assert property (p_nan) else $error("nan misclassified"); // RULE_16

	property p_inf;
		op_valid && a_word[30:0] == 31'h7F800000 |=> a_class_ff == fp_single_pkg::cls_infinity;
	endproperty
	a_inf: assert property (p_inf) else $error("infinity misclassified"); // RULE_15

endmodule

`default_nettype wire

// ### testbench/tb.sv
/*
 Self-checking bench for fp_single_unit: operand decode and result pack tables, then reset and flag cases.
 Assumes the design's one-cycle registered outputs; assertions live in the design files.
*/
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam fp_single_pkg::fp_class_t c_zero = fp_single_pkg::cls_zero;
	localparam fp_single_pkg::fp_class_t c_den = fp_single_pkg::cls_denormal;
	localparam fp_single_pkg::fp_class_t c_nor = fp_single_pkg::cls_normal;
	localparam fp_single_pkg::fp_class_t c_inf = fp_single_pkg::cls_infinity;
	localparam fp_single_pkg::fp_class_t c_nan = fp_single_pkg::cls_nan;
	localparam fp_single_pkg::fp_class_t c_ind = fp_single_pkg::cls_indefinite;

	typedef struct packed {
		logic [31:0] a;
		logic [31:0] b;
		fp_single_pkg::fp_class_t cls;
		logic q;
		logic n;
		logic [9:0] e;
		logic [23:0] s;
		logic eq;
		logic dn;
	} op_row_t;

	typedef struct packed {
		logic sg;
		logic [9:0] e;
		logic [23:0] s;
		logic [31:0] w;
		fp_single_pkg::fp_class_t cls;
		logic uf;
		logic ov;
	} res_row_t;

	// Exponent -126 is 10'h382, +128 is 10'h080
	op_row_t op_rows [0:11] = '{
		'{32'h00000000, 32'h80000000, c_zero, 1'h0, 1'h0, 10'h382, 24'h000000, 1'h1, 1'h0},
		'{32'h80000000, 32'h00000000, c_zero, 1'h0, 1'h1, 10'h382, 24'h000000, 1'h1, 1'h0},
		'{32'h00000001, 32'h00000002, c_den, 1'h0, 1'h0, 10'h382, 24'h000001, 1'h0, 1'h1},
		'{32'h3F800000, 32'h3F800000, c_nor, 1'h0, 1'h0, 10'h000, 24'h800000, 1'h1, 1'h0},
		'{32'h43322000, 32'h00800000, c_nor, 1'h0, 1'h0, 10'h007, 24'hB22000, 1'h0, 1'h0},
		'{32'h00800000, 32'h807FFFFF, c_nor, 1'h0, 1'h0, 10'h382, 24'h800000, 1'h0, 1'h1},
		'{32'h7F7FFFFF, 32'h7F800000, c_nor, 1'h0, 1'h0, 10'h07F, 24'hFFFFFF, 1'h0, 1'h0},
		'{32'hFF800000, 32'hFF800000, c_inf, 1'h0, 1'h1, 10'h080, 24'h800000, 1'h1, 1'h0},
		'{32'h7F800001, 32'h7F800001, c_nan, 1'h0, 1'h0, 10'h080, 24'h800001, 1'h0, 1'h0},
		'{32'h7FC00000, 32'h00000000, c_nan, 1'h1, 1'h0, 10'h080, 24'hC00000, 1'h0, 1'h0},
		'{32'hFFC00000, 32'hFFC00000, c_ind, 1'h1, 1'h1, 10'h080, 24'hC00000, 1'h0, 1'h0},
		'{32'h807FFFFF, 32'h00000000, c_den, 1'h0, 1'h1, 10'h382, 24'h7FFFFF, 1'h0, 1'h1}
	};

	res_row_t res_rows [0:9] = '{
		'{1'h0, 10'h37F, 24'hAE0000, 32'h0015C000, c_den, 1'h1, 1'h0},
		'{1'h1, 10'h00B, 24'h0B2200, 32'hC3322000, c_nor, 1'h0, 1'h0},
		'{1'h0, 10'h382, 24'h400000, 32'h00400000, c_den, 1'h1, 1'h0},
		'{1'h0, 10'h383, 24'h400000, 32'h00800000, c_nor, 1'h0, 1'h0},
		'{1'h0, 10'h36A, 24'h800000, 32'h00000000, c_zero, 1'h0, 1'h0},
		'{1'h0, 10'h36B, 24'h800000, 32'h00000001, c_den, 1'h1, 1'h0},
		'{1'h1, 10'h080, 24'h800000, 32'hFF800000, c_inf, 1'h0, 1'h1},
		'{1'h0, 10'h07F, 24'hFFFFFF, 32'h7F7FFFFF, c_nor, 1'h0, 1'h0},
		'{1'h1, 10'h000, 24'h000000, 32'h80000000, c_zero, 1'h0, 1'h0},
		'{1'h0, 10'h000, 24'h000001, 32'h34000000, c_nor, 1'h0, 1'h0}
	};

	logic clock;
	logic rst_n;
	logic op_valid;
	logic [31:0] a_word;
	logic [31:0] b_word;
	logic res_valid;
	logic res_sign;
	logic signed [9:0] res_exp;
	logic [23:0] res_sig;
	fp_single_pkg::fp_class_t a_class_ff;
	fp_single_pkg::fp_class_t b_class_ff;
	fp_single_pkg::fp_class_t res_class_ff;
	logic a_quiet_ff;
	logic b_quiet_ff;
	logic a_neg_ff;
	logic b_neg_ff;
	logic signed [9:0] a_exp_ff;
	logic signed [9:0] b_exp_ff;
	logic [23:0] a_sig_ff;
	logic [23:0] b_sig_ff;
	logic op_valid_ff;
	logic equal_ff;
	logic denorm_operand_ff;
	logic res_valid_ff;
	logic [31:0] res_word_ff;
	logic underflow_ff;
	logic overflow_ff;
	int miscompares = 0;
	int comparisons = 0;

	fp_single_unit i_dut
	(
		.clock(clock),
		.rst_n(rst_n),
		.op_valid(op_valid),
		.a_word(a_word),
		.b_word(b_word),
		.res_valid(res_valid),
		.res_sign(res_sign),
		.res_exp(res_exp),
		.res_sig(res_sig),
		.a_class_ff(a_class_ff),
		.b_class_ff(b_class_ff),
		.a_quiet_ff(a_quiet_ff),
		.b_quiet_ff(b_quiet_ff),
		.a_neg_ff(a_neg_ff),
		.b_neg_ff(b_neg_ff),
		.a_exp_ff(a_exp_ff),
		.b_exp_ff(b_exp_ff),
		.a_sig_ff(a_sig_ff),
		.b_sig_ff(b_sig_ff),
		.op_valid_ff(op_valid_ff),
		.equal_ff(equal_ff),
		.denorm_operand_ff(denorm_operand_ff),
		.res_valid_ff(res_valid_ff),
		.res_word_ff(res_word_ff),
		.res_class_ff(res_class_ff),
		.underflow_ff(underflow_ff),
		.overflow_ff(overflow_ff)
	);

	////////////////////////////////////////////////////////////////////////////////

	// Exponents go in through a concatenation so they are not sign-extended
	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		comparisons++;
		if (seen !== want)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial
	begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	initial
	begin
		repeat (1000) @(posedge clock);
		miscompares++;
		report_and_stop();
	end

	initial
	begin
		rst_n = 1'h0;
		op_valid = 1'h0;
		a_word = 32'h00000001;
		b_word = 32'h00000001;
		// Qualifiers stay low over the release edge so no check starts while the registers still hold reset
		res_valid = 1'h0;
		res_sign = 1'h0;
		res_exp = 10'h37F;
		res_sig = 24'hAE0000;
		repeat (5) @(posedge clock);
		#1;
		chk(a_class_ff, c_zero, "reset class");
		chk(res_word_ff, 32'h00000000, "reset word");
		chk(underflow_ff, 1'h0, "reset underflow");
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		// Back to back: each edge loads a new row while the previous one is checked
		for (int i = 0; i <= 12; i++)
		begin
			@(posedge clock);
			if (i < 12)
			begin
				op_valid <= 1'h1;
				res_valid <= 1'h1;
				a_word <= op_rows[i].a;
				b_word <= op_rows[i].b;
			end
			#1;
			if (i > 0)
			begin
				chk(a_class_ff, op_rows[i-1].cls, "class");
				chk(a_quiet_ff, op_rows[i-1].q, "quiet");
				chk(a_neg_ff, op_rows[i-1].n, "sign");
				chk({a_exp_ff}, op_rows[i-1].e, "exponent");
				chk(a_sig_ff, op_rows[i-1].s, "significand");
				chk(equal_ff, op_rows[i-1].eq, "equal");
				chk(denorm_operand_ff, op_rows[i-1].dn, "denormal operand");
				chk(op_valid_ff, 1'h1, "operand valid");
			end
		end
		for (int i = 0; i <= 10; i++)
		begin
			@(posedge clock);
			if (i < 10)
			begin
				res_sign <= res_rows[i].sg;
				res_exp <= res_rows[i].e;
				res_sig <= res_rows[i].s;
			end
			#1;
			if (i > 0)
			begin
				chk(res_word_ff, res_rows[i-1].w, "result word");
				chk(res_class_ff, res_rows[i-1].cls, "result class");
				chk(underflow_ff, res_rows[i-1].uf, "underflow");
				chk(overflow_ff, res_rows[i-1].ov, "overflow");
				chk(res_valid_ff, 1'h1, "result valid");
			end
		end
		// Qualifiers low: decode and packing still run, flags stay quiet
		@(posedge clock);
		op_valid <= 1'h0;
		a_word <= 32'h00000001;
		b_word <= 32'h80000001;
		res_valid <= 1'h0;
		res_sign <= 1'h0;
		res_exp <= 10'h37F;
		res_sig <= 24'hAE0000;
		@(posedge clock);
		#1;
		chk(denorm_operand_ff, 1'h0, "denormal operand gated");
		chk(op_valid_ff, 1'h0, "operand valid low");
		chk(b_class_ff, c_den, "b class");
		chk(b_neg_ff, 1'h1, "b sign");
		chk({b_exp_ff}, 10'h382, "b exponent");
		chk(b_sig_ff, 24'h000001, "b significand");
		chk(b_quiet_ff, 1'h0, "b quiet");
		chk(underflow_ff, 1'h0, "underflow gated");
		chk(res_valid_ff, 1'h0, "result valid low");
		chk(res_word_ff, 32'h0015C000, "word while idle");
		// Reset in mid-run clears the registers at once
		@(posedge clock);
		op_valid <= 1'h1;
		res_valid <= 1'h1;
		@(posedge clock);
		rst_n <= 1'h0;
		op_valid <= 1'h0;
		res_valid <= 1'h0;
		#1;
		chk(a_class_ff, c_zero, "mid reset class");
		chk(res_word_ff, 32'h00000000, "mid reset word");
		chk(op_valid_ff, 1'h0, "mid reset valid");
		chk(underflow_ff, 1'h0, "mid reset underflow");
		chk(denorm_operand_ff, 1'h0, "mid reset denormal operand");
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		op_valid <= 1'h1;
		res_valid <= 1'h1;
		@(posedge clock);
		#1;
		chk(underflow_ff, 1'h1, "underflow after reset");
		chk(denorm_operand_ff, 1'h1, "denormal operand after reset");
		report_and_stop();
	end
endmodule

`default_nettype wire
